// file: rtl/chpp_pkg.sv
// Constants, register map and state encoding of the input power path control
package chpp_pkg;

   // Clock and timing
   localparam int unsigned CLK_HZ        = 100_000_000;  // Control clock rate
   localparam int unsigned RETRY_S       = 2;            // Poor source retry period, seconds
   localparam int unsigned RETRY_CYC     = RETRY_S * CLK_HZ;
   localparam int unsigned BOOST_DLY_MS  = 22;           // Boost start delay, milliseconds
   localparam int unsigned BOOST_DLY_CYC = BOOST_DLY_MS * (CLK_HZ / 1000);
   localparam int unsigned QUAL_US       = 10;           // Test load settle time, microseconds
   localparam int unsigned QUAL_CYC      = QUAL_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CNT_W         = 28;           // Wide enough for the retry period

   // Register byte offsets on the bus
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFS_INPUT_SOURCE_CONTROL  = 8'h00;
   localparam logic [7:0] OFS_POWER_ON_CONFIG       = 8'h04;
   localparam logic [7:0] OFS_MISC_OPERATION_CONTROL = 8'h1C;
   localparam logic [7:0] OFS_SYSTEM_STATUS         = 8'h20;
   localparam logic [7:0] OFS_FAULT_STATUS          = 8'h24;
   localparam logic [7:0] OFS_MODE_CONTROL          = 8'h28;

   // Field positions
   localparam int unsigned F_STANDBY  = 7;   // input_source_control
   localparam int unsigned F_VLIM_LO  = 3;   // input_source_control [6:3]
   localparam int unsigned F_EXTERNAL_LIMIT_PIN_LO  = 0;   // input_source_control [2:0]
   localparam int unsigned F_CFG_LO   = 4;   // power_on_config [5:4]
   localparam int unsigned F_MINSYS_LO = 1;  // power_on_config [3:1]
   localparam int unsigned F_BOOST_HI = 0;   // power_on_config [0]
   localparam int unsigned F_FORCE    = 7;   // misc_operation_control
   localparam int unsigned F_BSW_OFF  = 5;   // misc_operation_control
   localparam int unsigned F_SRC_LO   = 6;   // system_status [7:6]
   localparam int unsigned F_THROT    = 3;   // system_status
   localparam int unsigned F_PG       = 2;   // system_status
   localparam int unsigned F_MINSYS_ST = 0;  // system_status
   localparam int unsigned F_BFAULT   = 6;   // fault_status
   localparam int unsigned F_HOSTMODE = 0;   // mode_control

   // Reset values
   localparam logic [3:0] VLIM_RST   = 4'h6;
   localparam logic [2:0] EXTERNAL_LIMIT_PIN_RST   = 3'h2;
   localparam logic [1:0] CFG_RST    = 2'h1;
   localparam logic [2:0] MINSYS_RST = 3'h5;  // 3.5V step

   // Configuration and code values
   localparam logic [1:0] CFG_CHARGE = 2'h1;
   localparam logic [1:0] CFG_BOOST  = 2'h2;
   localparam logic [1:0] SRC_NONE   = 2'h0;
   localparam logic [1:0] SRC_HOST   = 2'h1;
   localparam logic [1:0] SRC_ADAPT  = 2'h2;
   localparam logic [1:0] SRC_BOOST  = 2'h3;
   localparam logic [2:0] EXTERNAL_LIMIT_PIN_100   = 3'h0;
   localparam logic [2:0] EXTERNAL_LIMIT_PIN_500   = 3'h2;
   localparam logic [2:0] EXTERNAL_LIMIT_PIN_1500  = 3'h5;

   // Synchronised input bit positions
   localparam int unsigned SY_PRESENT = 0;
   localparam int unsigned SY_NOOVP   = 1;
   localparam int unsigned SY_NOPOOR  = 2;
   localparam int unsigned SY_PORT    = 3;
   localparam int unsigned SY_OTG     = 4;
   localparam int unsigned SY_BATGD   = 5;
   localparam int unsigned SY_BATLOW  = 6;
   localparam int unsigned SY_SLEEP   = 7;
   localparam int unsigned SY_SYS22   = 8;
   localparam int unsigned SY_BATMIN  = 9;
   localparam int unsigned SY_LIGHT   = 10;
   localparam int unsigned SY_MINREG  = 11;
   localparam int unsigned SY_IOVER   = 12;
   localparam int unsigned SY_VUNDER  = 13;
   localparam int unsigned SY_SYSBAT  = 14;
   localparam int unsigned SY_DEPL    = 15;
   localparam int unsigned SY_BFAULT  = 16;
   localparam int unsigned SY_EXT_LO  = 17;  // Three bits of external limit code
   localparam int unsigned SY_W       = 20;

   // Control states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE   = 8'h01,
      ST_QUAL   = 8'h02,
      ST_RETRY  = 8'h04,
      ST_DETECT = 8'h08,
      ST_STBY   = 8'h10,
      ST_RUN    = 8'h20,
      ST_BWAIT  = 8'h40,
      ST_BOOST  = 8'h80
   } chpp_state_t;

endpackage : chpp_pkg

// file: rtl/chpp_top.sv
// Input power path control: qualification, limit detection, standby, boost
`timescale 1ns/1ps

module chpp_top #(
   parameter int unsigned RETRY_CYCLES = chpp_pkg::RETRY_CYC,     // Poor source retry wait
   parameter int unsigned BOOST_CYCLES = chpp_pkg::BOOST_DLY_CYC, // Boost start delay
   parameter int unsigned QUAL_CYCLES  = chpp_pkg::QUAL_CYC       // Test load settle
) (
   // Clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   // Wishbone slave
   input  wire logic                        cyc_i,
   input  wire logic                        stb_i,
   input  wire logic                        we_i,
   input  wire logic [chpp_pkg::ADDR_W-1:0] adr_i,
   input  wire logic [3:0]                  sel_i,
   input  wire logic [31:0]                 dat_i,
   output logic      [31:0]                 dat_o,
   output logic                             ack_o,
   // Comparator and pin inputs, asynchronous
   input  wire logic                        bus_present_i,
   input  wire logic                        bus_below_ovp_i,
   input  wire logic                        bus_above_poor_i,
   input  wire logic                        port_type_i,
   input  wire logic                        boost_request_pin_i,
   input  wire logic                        bat_above_good_i,
   input  wire logic                        bat_above_low_i,
   input  wire logic                        bus_below_bat_sleep_i,
   input  wire logic                        sys_above_2v2_i,
   input  wire logic                        bat_below_minsys_i,
   input  wire logic                        light_load_i,
   input  wire logic                        in_minsys_reg_i,
   input  wire logic                        in_current_over_i,
   input  wire logic                        in_voltage_under_i,
   input  wire logic                        sys_below_bat_i,
   input  wire logic                        bat_below_depl_i,
   input  wire logic                        boost_fault_i,
   input  wire logic [2:0]                  external_limit_pin_i,
   // Control outputs
   output logic                             power_good_n_o,
   output logic                             int_o,
   output logic                             test_load_o,
   output logic                             high_impedance_standby_o,
   output logic                             converter_en_o,
   output logic                             battery_switch_o,
   output logic                             pfm_mode_o,
   output logic                             boost_en_o,
   output logic                             boost_external_limit_pin_hi_o,
   output logic                             charge_reduce_o,
   output logic      [2:0]                  external_limit_pin_code_o,
   output logic      [3:0]                  vlim_code_o,
   output logic      [2:0]                  minsys_code_o
);
   import chpp_pkg::*;

   // Whole module state
   typedef struct packed {
      logic [SY_W-1:0]  s1;        // First synchroniser stage
      logic [SY_W-1:0]  s2;        // Second synchroniser stage
      chpp_state_t      state;     // Sequencer state
      logic [CNT_W-1:0] cnt;       // Delay counter
      logic             standby;   // Standby control bit
      logic [3:0]       vlim;      // Input voltage limit field
      logic [2:0]       external_limit_pin;      // Input current limit field
      logic [1:0]       cfg;       // Charge or boost configuration
      logic [2:0]       minsys;    // Minimum system voltage field
      logic             boost_hi;  // Boost current select
      logic             force_det; // Force detection bit
      logic             bsw_off;   // Battery switch forced off
      logic             host_mode; // Host mode, else default mode
      logic [1:0]       src;       // Source type code
      logic             pg;        // Power good
      logic             bfault;    // Boost fault, sticky
      logic             ack;       // Bus acknowledge
      logic [31:0]      dat;       // Bus read data
      logic             irq;       // Interrupt pulse
      logic             load;      // Test load applied
      logic [2:0]       external_limit_pin_eff;  // Limit sent to the converter
      logic             conv_en;   // Buck converter switching
      logic             bsw_on;    // Battery switch drive
      logic             pulse_frequency_control;       // Pulse-frequency control
      logic             boost_en;  // Boost converter on
      logic             reduce;    // Charge current reduction
   } chpp_st_t;

   chpp_st_t r;       // Current state
   chpp_st_t next_r;  // Next state

   logic [SY_W-1:0] raw;   // Asynchronous inputs gathered
   logic [SY_W-1:0] sy;    // Synchronised view
   logic            boost_ok;
   logic            chg_en;
   logic            dev_stby;
   logic            dev_fault;
   logic            wr;
   logic            rd;

   // Register select by word index
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
   endfunction : hit

   // Lower of two limit codes
   function automatic logic [2:0] lower(input logic [2:0] a, input logic [2:0] b);
      lower = (a < b) ? a : b;
   endfunction : lower

   // Gather pins; the limit code passes the same two stages as the rest
   assign raw = {external_limit_pin_i, boost_fault_i, bat_below_depl_i, sys_below_bat_i,
                 in_voltage_under_i, in_current_over_i, in_minsys_reg_i, light_load_i,
                 bat_below_minsys_i, sys_above_2v2_i, bus_below_bat_sleep_i,
                 bat_above_low_i, bat_above_good_i, boost_request_pin_i, port_type_i,
                 bus_above_poor_i, bus_below_ovp_i, bus_present_i};

   // only the second stage is read
   assign sy = r.s2;

   // Next state logic
   always_comb begin
      next_r    = r;
      dev_stby  = 1'b0;
      dev_fault = 1'b0;
      next_r.s1 = raw;
      next_r.s2 = r.s1;
      next_r.irq = 1'b0;
      next_r.ack = 1'b0;
      wr = cyc_i & stb_i & r.ack & we_i & sel_i[0];
      rd = cyc_i & stb_i & r.ack & ~we_i;
      boost_ok = sy[SY_BATLOW] & sy[SY_SLEEP] & sy[SY_OTG] & (r.cfg == CFG_BOOST);
      chg_en   = (r.cfg == CFG_CHARGE) & ~r.bsw_off;
      // Counter runs by default, states reload it
      if (r.cnt != '0) begin
         next_r.cnt = r.cnt - 1'b1;
      end

      case (r.state)
         // No source: wait for attach or a boost request
         ST_IDLE: begin
            next_r.load = 1'b0;
            next_r.src  = SRC_NONE;
            if (sy[SY_PRESENT]) begin
               next_r.state = ST_QUAL;
               next_r.load  = 1'b1;
               next_r.cnt   = CNT_W'(QUAL_CYCLES);
            end else if (boost_ok) begin
               next_r.state = ST_BWAIT;
               next_r.cnt   = CNT_W'(BOOST_CYCLES);
            end
         end
         // Test load on, judge once settled
         ST_QUAL: begin
            if (!sy[SY_PRESENT]) begin
               next_r.state = ST_IDLE;
            end else if (r.cnt == '0) begin
               next_r.load = 1'b0;
               if (sy[SY_NOOVP] && sy[SY_NOPOOR]) begin
                  next_r.pg  = 1'b1;
                  next_r.irq = 1'b1;
                  if (r.host_mode && r.standby) begin
                     next_r.state = ST_STBY;
                  end else begin
                     next_r.state = ST_DETECT;
                  end
               end else begin
                  next_r.state = ST_RETRY;
                  next_r.cnt   = CNT_W'(RETRY_CYCLES);
               end
            end
         end
         // Waiting out the retry period
         ST_RETRY: begin
            if (!sy[SY_PRESENT]) begin
               next_r.state = ST_IDLE;
            end else if (r.cnt == '0) begin
               next_r.state = ST_QUAL;
               next_r.load  = 1'b1;
               next_r.cnt   = CNT_W'(QUAL_CYCLES);
            end
         end
         // One-cycle limit detection from the pins
         ST_DETECT: begin
            next_r.force_det = 1'b0;
            // port type low means charging port
            if (!sy[SY_PORT]) begin
               next_r.external_limit_pin  = EXTERNAL_LIMIT_PIN_1500;
               next_r.src   = SRC_ADAPT;
               next_r.state = ST_RUN;
            end else if (!sy[SY_OTG] && sy[SY_BATGD]) begin
               next_r.external_limit_pin    = EXTERNAL_LIMIT_PIN_100;
               next_r.src     = SRC_HOST;
               next_r.standby = 1'b1;
               dev_stby       = 1'b1;
               next_r.state   = ST_STBY;
            end else begin
               next_r.external_limit_pin  = sy[SY_OTG] ? EXTERNAL_LIMIT_PIN_500 : EXTERNAL_LIMIT_PIN_100;
               next_r.src   = SRC_HOST;
               next_r.state = ST_RUN;
            end
         end
         // Lowest quiescent state, converter off
         ST_STBY: begin
            // host mode holds it through removal
            if (!sy[SY_PRESENT] && (!r.host_mode || !r.standby)) begin
               next_r.state = ST_IDLE;
            end else if (sy[SY_PRESENT] && (!r.standby || r.force_det)) begin
               // Bit cleared or detection forced
               next_r.state = ST_DETECT;
            end
         end
         // Converter running from the source
         ST_RUN: begin
            if (!sy[SY_PRESENT]) begin
               next_r.state = ST_IDLE;
            end else if (r.force_det) begin
               next_r.state = ST_DETECT;
            end else if (r.standby) begin
               next_r.state = ST_STBY;
            end
         end
         // Boost start delay, abandoned if a condition drops
         ST_BWAIT: begin
            if (!boost_ok || sy[SY_PRESENT]) begin
               next_r.state = ST_IDLE;
            end else if (r.cnt == '0) begin
               next_r.state = ST_BOOST;
               next_r.src   = SRC_BOOST;
            end
         end
         // Boost running
         ST_BOOST: begin
            if (sy[SY_BFAULT]) begin
               next_r.bfault = 1'b1;
               dev_fault     = 1'b1;
               next_r.irq    = 1'b1;
               next_r.state  = ST_IDLE;
            end else if (!boost_ok) begin
               next_r.state = ST_IDLE;
            end
         end
         default: begin
            next_r.state = ST_IDLE;
         end
      endcase

      // Source removal drops power good from any buck state
      if (!sy[SY_PRESENT] && r.state != ST_BWAIT && r.state != ST_BOOST) begin
         next_r.pg = 1'b0;
         // default mode forgets standby on removal
         if (!r.host_mode) begin
            next_r.standby = 1'b0;
         end
      end

      // Register writes; device sets win over host writes
      if (wr) begin
         if (hit(adr_i, OFS_INPUT_SOURCE_CONTROL)) begin
            if (!dev_stby) begin
               next_r.standby = dat_i[F_STANDBY];
            end
            next_r.vlim = dat_i[F_VLIM_LO +: 4];
            // host rewrite of the limit field
            if (r.state != ST_DETECT) begin
               next_r.external_limit_pin = dat_i[F_EXTERNAL_LIMIT_PIN_LO +: 3];
            end
         end
         if (hit(adr_i, OFS_POWER_ON_CONFIG)) begin
            next_r.cfg      = dat_i[F_CFG_LO +: 2];
            next_r.minsys   = dat_i[F_MINSYS_LO +: 3];
            next_r.boost_hi = dat_i[F_BOOST_HI];
         end
         if (hit(adr_i, OFS_MISC_OPERATION_CONTROL)) begin
            // host request; a write of 0 does not cancel
            next_r.force_det = next_r.force_det | dat_i[F_FORCE];
            next_r.bsw_off   = dat_i[F_BSW_OFF];
         end
         if (hit(adr_i, OFS_MODE_CONTROL)) begin
            next_r.host_mode = dat_i[F_HOSTMODE];
         end
      end

      // Fault status clears on read, a new fault wins
      if (rd && hit(adr_i, OFS_FAULT_STATUS) && !dev_fault) begin
         next_r.bfault = 1'b0;
      end

      // Bus answer, one cycle after the request is seen
      if (cyc_i && stb_i && !r.ack) begin
         next_r.ack = 1'b1;
         next_r.dat = '0;
         if (hit(adr_i, OFS_INPUT_SOURCE_CONTROL)) begin
            next_r.dat[7:0] = {r.standby, r.vlim, r.external_limit_pin};
         end else if (hit(adr_i, OFS_POWER_ON_CONFIG)) begin
            next_r.dat[7:0] = {2'h0, r.cfg, r.minsys, r.boost_hi};
         end else if (hit(adr_i, OFS_MISC_OPERATION_CONTROL)) begin
            next_r.dat[F_FORCE]   = r.force_det;
            next_r.dat[F_BSW_OFF] = r.bsw_off;
         end else if (hit(adr_i, OFS_SYSTEM_STATUS)) begin
            next_r.dat[F_SRC_LO +: 2] = r.src;
            next_r.dat[F_THROT]       = r.reduce;
            next_r.dat[F_PG]          = r.pg;
            next_r.dat[F_MINSYS_ST]   = sy[SY_MINREG];
         end else if (hit(adr_i, OFS_FAULT_STATUS)) begin
            next_r.dat[F_BFAULT] = r.bfault;
         end else if (hit(adr_i, OFS_MODE_CONTROL)) begin
            next_r.dat[F_HOSTMODE] = r.host_mode;
         end
      end

      // Converter drive, registered for clean outputs
      // switching starts once the limit is set
      next_r.conv_en  = (r.state == ST_RUN) & (next_r.state == ST_RUN);
      next_r.boost_en = (r.state == ST_BOOST);
      // soft-start limit during a low system rail
      next_r.external_limit_pin_eff = sy[SY_SYS22] ? lower(r.external_limit_pin, sy[SY_EXT_LO +: 3]) : EXTERNAL_LIMIT_PIN_100;
      // light load with low battery or no charging
      next_r.pulse_frequency_control = (r.state == ST_RUN) & sy[SY_LIGHT] & (sy[SY_BATMIN] | ~chg_en);
      next_r.reduce = (r.state == ST_RUN) & (sy[SY_IOVER] | sy[SY_VUNDER]);
      // Battery switch: forced off beats everything
      if (r.bsw_off || sy[SY_DEPL]) begin
         next_r.bsw_on = 1'b0;
      end else if (r.state == ST_RUN) begin
         next_r.bsw_on = chg_en | sy[SY_SYSBAT];
      end else begin
         // Battery feeds the system with no converter
         next_r.bsw_on = 1'b1;
      end
   end

   // State register with synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r          <= '0;
         r.state    <= ST_IDLE;
         r.vlim     <= VLIM_RST;
         r.external_limit_pin     <= EXTERNAL_LIMIT_PIN_RST;
         r.cfg      <= CFG_RST;
         r.minsys   <= MINSYS_RST;
         r.external_limit_pin_eff <= EXTERNAL_LIMIT_PIN_100;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state register
   assign dat_o                    = r.dat;
   assign ack_o                    = r.ack;
   assign power_good_n_o           = ~r.pg;
   assign int_o                    = r.irq;
   assign test_load_o              = r.load;
   assign high_impedance_standby_o = (r.state == ST_STBY);
   assign converter_en_o           = r.conv_en;
   assign battery_switch_o         = r.bsw_on;
   assign pfm_mode_o               = r.pulse_frequency_control;
   assign boost_en_o               = r.boost_en;
   assign boost_external_limit_pin_hi_o          = r.boost_hi;
   assign charge_reduce_o          = r.reduce;
   assign external_limit_pin_code_o              = r.external_limit_pin_eff;
   assign vlim_code_o              = r.vlim;
   assign minsys_code_o            = r.minsys;

endmodule : chpp_top

// file: tb/chpp_checker_assertions.sv
// Concurrent checks on the power path control ports
`timescale 1ns/1ps
module chpp_checker (
   input wire logic       clk_i, rst_i, cyc_i, stb_i, ack_o, power_good_n_o, int_o,
   input wire logic       test_load_o, converter_en_o, high_impedance_standby_o,
   input wire logic       boost_en_o, sys_above_2v2_i,
   input wire logic [2:0] external_limit_pin_code_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack");
   AST_ACK_ONE: assert property (ack_o |=> !ack_o) else $error("ack long");
   AST_PG_INT: assert property ($fell(power_good_n_o) |-> int_o) else $error("no int");
   AST_PG_LOAD: assert property ($fell(power_good_n_o) |-> $past(test_load_o))
      else $error("untested");
   AST_LOAD_PG: assert property ($rose(test_load_o) |-> power_good_n_o) else $error("load");
   AST_STBY_OFF: assert property (high_impedance_standby_o |-> !converter_en_o)
      else $error("standby");
   AST_BOOST_PG: assert property (boost_en_o |-> power_good_n_o) else $error("boost");
   AST_SOFT: assert property (converter_en_o && !$past(sys_above_2v2_i, 2)
      && !$past(sys_above_2v2_i, 3) && !$past(sys_above_2v2_i, 4) |-> external_limit_pin_code_o == 3'h0)
      else $error("soft start");
endmodule : chpp_checker

// file: tb/chpp_phy_model.sv
// Port detection output of the USB PHY
`timescale 1ns/1ps
module chpp_phy_model (
   input  wire logic clk_i,       // Clock
   input  wire logic usb_host_i,  // Bench picks the port kind
   output logic      port_type_o  // High for a USB host port
);
   always_ff @(posedge clk_i) port_type_o <= usb_host_i;
endmodule : chpp_phy_model

// file: tb/chpp_top_tb_top.sv
// Self-checking bench of the input power path control
`timescale 1ns/1ps
module chpp_top_tb_top;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, usb_host, bus_present_i, bus_below_ovp_i;
   logic bus_above_poor_i, port_type_i, boost_request_pin_i, bat_above_good_i, int_o;
   logic bat_above_low_i, bus_below_bat_sleep_i, sys_above_2v2_i, bat_below_minsys_i;
   logic light_load_i, in_minsys_reg_i, in_current_over_i, in_voltage_under_i, pfm_mode_o;
   logic sys_below_bat_i, bat_below_depl_i, boost_fault_i, power_good_n_o, test_load_o;
   logic high_impedance_standby_o, converter_en_o, battery_switch_o, boost_en_o;
   logic boost_external_limit_pin_hi_o, charge_reduce_o;
   logic [31:0] dat_i, dat_o, q;
   logic [7:0]  adr_i;
   logic [6:0]  noise = '0, pick;
   logic        hold = 1'b0;
   logic [4:0]  obs;
   logic [3:0]  sel_i, vlim_code_o;
   logic [2:0]  external_limit_pin_i, external_limit_pin_code_o, minsys_code_o, ex, sd;
   logic [2:0]  tab [3] = '{3'h0, 3'h2, 3'h5};
   int          seed = 4274, errors = 0, compares = 0, i, n;
   // Short counts keep the run brief
   chpp_top #(.RETRY_CYCLES(50), .BOOST_CYCLES(40), .QUAL_CYCLES(4)) i_chpp_top (.*);
   chpp_phy_model i_chpp_phy_model (.clk_i(clk_i), .usb_host_i(usb_host),
      .port_type_o(port_type_i));
   assign obs = {ack_o, boost_en_o, high_impedance_standby_o, converter_en_o, power_good_n_o};
   assign {light_load_i, in_minsys_reg_i, in_current_over_i, in_voltage_under_i,
      sys_below_bat_i, bat_below_depl_i, bat_below_minsys_i} = hold ? pick : noise;
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Unjudged comparators wander
   always @(posedge clk_i) noise <= 7'($random(seed));
   task conclude;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   task chk(input string nm, input logic [31:0] s, e);
      compares++;
      errors += (s !== e);
      if (s !== e) $display("wrong value %s expected %h seen %h", nm, e, s);
   endtask : chk
   // Expected pulse mode, throttle and switch while running
   function automatic logic [2:0] side(input logic [6:0] v, input logic c);
      side = {v[6] & (v[0] | !c), v[4] | v[3], !v[1] & (c | v[2])};
   endfunction : side
   // Bounded wait on one watched output
   task wt(input int k, input logic v);
      for (n = 0; n < 300 && obs[k] !== v; n++) @(posedge clk_i);
      errors += (n == 300);
      if (n == 300) conclude;
   endtask : wt
   // Classic cycle held until ack is sampled
   task wb(input logic w, input logic [7:0] a, d);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
      @(posedge clk_i);
      wt(4, 1'b1);
      q = dat_o;
      {cyc_i, stb_i} <= 2'b00;
   endtask : wb
   initial begin
      {rst_i, bus_below_ovp_i, sel_i, external_limit_pin_i} = 9'h1FF;
      {cyc_i, stb_i, we_i, adr_i, dat_i, usb_host, bus_present_i, bus_above_poor_i} = '0;
      {boost_request_pin_i, bat_above_good_i, bat_above_low_i, bus_below_bat_sleep_i} = '0;
      {sys_above_2v2_i, boost_fault_i} = '0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 8'h04, 8'h00);
      chk("config", q, 32'h1A);
      for (i = 0; i < 3; i++) begin
         ex = 3'($random(seed));
         {usb_host, boost_request_pin_i, external_limit_pin_i} <= {i < 2, i == 1, ex};
         {sys_above_2v2_i, bus_above_poor_i, bus_present_i} <= 3'b001;
         repeat (70) @(posedge clk_i);
         chk("poor", 32'(power_good_n_o), 32'h1);
         bus_above_poor_i <= 1'b1;
         wt(0, 1'b0);
         wt(1, 1'b1);
         repeat (6) @(posedge clk_i);
         chk("soft", 32'(external_limit_pin_code_o), 32'h0);
         sys_above_2v2_i <= 1'b1;
         repeat (6) @(posedge clk_i);
         chk("limit", 32'(external_limit_pin_code_o), 32'(tab[i] < ex ? tab[i] : ex));
         wb(1'b0, 8'h20, 8'h00);
         chk("status", q & 32'hC4, {24'h0, i < 2 ? 2'b01 : 2'b10, 6'h04});
         bus_present_i <= 1'b0;
         wt(0, 1'b1);
         $display("detect case %0d done", i);
      end
      // Host limit rewrite, then forced detection restores it
      bus_present_i <= 1'b1;
      wt(1, 1'b1);
      wb(1'b1, 8'h00, 8'h48);
      repeat (4) @(posedge clk_i);
      chk("rewrite", 32'(external_limit_pin_code_o), 32'h0);
      chk("vlim", 32'(vlim_code_o), 32'h9);
      wb(1'b1, 8'h1C, 8'h80);
      repeat (5) @(posedge clk_i);
      wb(1'b0, 8'h1C, 8'h00);
      chk("force", q & 32'h80, 32'h0);
      chk("redetect", 32'(external_limit_pin_code_o), 32'(tab[2] < ex ? tab[2] : ex));
      // Comparator mix while running, charging on then off
      for (i = 0; i < 8; i++) begin
         if (i == 4) wb(1'b1, 8'h04, 8'h0A);
         {hold, pick} <= {1'b1, 7'($random(seed))};
         repeat (5) @(posedge clk_i);
         sd = side(pick, i < 4);
         chk("pfm", 32'(pfm_mode_o), 32'(sd[2]));
         chk("throttle", 32'(charge_reduce_o), 32'(sd[1]));
         chk("switch", 32'(battery_switch_o), 32'(sd[0]));
         wb(1'b0, 8'h20, 8'h00);
         chk("minreg", 32'({q[3], q[0]}), 32'({sd[1], pick[5]}));
      end
      hold <= 1'b0;
      $display("running case done");
      bus_present_i <= 1'b0;
      wt(0, 1'b1);
      // Host mode standby outlives removal
      wb(1'b1, 8'h28, 8'h01);
      {usb_host, boost_request_pin_i, bat_above_good_i, bus_present_i} <= 4'b1011;
      wt(2, 1'b1);
      bus_present_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      wb(1'b0, 8'h00, 8'h00);
      chk("standby", 32'({q[7], high_impedance_standby_o}), 32'h3);
      wb(1'b1, 8'h00, 8'h32);
      wt(2, 1'b0);
      $display("standby case done");
      // Boost waits its delay, then reports
      bat_above_good_i <= 1'b0;
      wb(1'b1, 8'h04, 8'h2B);
      chk("minsys", 32'(minsys_code_o), 32'h5);
      {boost_request_pin_i, bat_above_low_i, bus_below_bat_sleep_i} <= 3'b111;
      repeat (20) @(posedge clk_i);
      chk("early boost", 32'(boost_en_o), 32'h0);
      wt(3, 1'b1);
      wb(1'b0, 8'h20, 8'h00);
      chk("boost", 32'({q[7:6], boost_external_limit_pin_hi_o}), 32'h7);
      boost_fault_i <= 1'b1;
      wt(3, 1'b0);
      wb(1'b0, 8'h24, 8'h00);
      chk("fault", q & 32'h40, 32'h40);
      $display("boost case done");
      conclude;
   end
endmodule : chpp_top_tb_top
bind chpp_top chpp_checker i_chpp_checker (.*);
